/* File: src/slrx_pkg.sv */
package slrx_pkg;

    // ****************************************************************
    // register addresses
    // ****************************************************************
    localparam int          ADDR_W           = 12;
    localparam logic [11:0] ADDR_TERM_CAL_B  = 12'h2ae;
    localparam logic [11:0] ADDR_TERM_SET_A  = 12'h2b1;
    localparam logic [11:0] ADDR_TERM_SET_B  = 12'h2b2;
    localparam logic [11:0] ADDR_RX_GEN_CTRL = 12'h300;
    localparam logic [11:0] ADDR_CFG_FIRST   = 12'h400;
    localparam logic [11:0] ADDR_CFG_LAST    = 12'h40a;
    localparam logic [11:0] ADDR_CKSUM_FIRST = 12'h40e;
    localparam logic [11:0] ADDR_CKSUM_LAST  = 12'h446;
    localparam logic [2:0]  CKSUM_LANE_LSB   = 3'h6;   // stride of 8 bytes
    localparam logic [3:0]  CFG_LAST_IDX     = 4'ha;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [7:0]  RST_TERM_CAL_B   = 8'h00;
    localparam logic [7:0]  RST_TERM_SET_A   = 8'hc3;
    localparam logic [7:0]  RST_TERM_SET_B   = 8'h93;
    localparam logic [7:0]  RST_CKSUM        = 8'h00;

    // ****************************************************************
    // field positions of the general receiver control and group B calibrate registers
    // ****************************************************************
    localparam int          BIT_CKSUM_MODE   = 6;
    localparam int          BIT_LINK_MODE    = 3;
    localparam int          BIT_LINK_PAGE    = 2;
    localparam int          BIT_TERM_CAL     = 0;

    // general receiver control fields
    typedef struct packed {
        logic       cksum_mode;
        logic       link_mode;
        logic       link_page;
        logic [1:0] link_en;
    } slrx_ctrl_t;

    // register access request
    typedef struct packed {
        logic [11:0] addr;
        logic        wr;
        logic        rd;
        logic [7:0]  wdata;
    } slrx_req_t;

    // checksum sequencer states
    typedef enum logic [2:0] {
        SEQ_IDLE = 3'b001,
        SEQ_RUN  = 3'b010,
        SEQ_DONE = 3'b100
    } slrx_seq_t;

endpackage

/* File: src/slrx_cfg_mem.sv */
`timescale 1ns/1ps
// link configuration byte store, registered read data
module slrx_cfg_mem #(
    parameter int DW = 8,
    parameter int AW = 5
) (
    input  wire logic          i_clk_sys,
    input  wire logic          i_reset,
    input  wire logic          i_we,
    input  wire logic [AW-1:0] i_waddr,
    input  wire logic [DW-1:0] i_wdata,
    input  wire logic [AW-1:0] i_raddr,
    output logic      [DW-1:0] o_rdata
);

    logic [DW-1:0] mem [2**AW];

    // write port
    always_ff @(posedge i_clk_sys) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
    end

    // read port
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_rdata <= '0;
        end else begin
            o_rdata <= mem[i_raddr];
        end
    end

endmodule

/* File: src/slrx_gen_ctrl.sv */
`timescale 1ns/1ps
// Operation
// - rising edge of group B calibrate bit calibrates lanes 2-5 to 50 ohms
// - checksum mode 1 sums bytes 0x400 to 0x40A modulo 256
// - checksum copied into all eight lane checksum registers
// - control bit 3 selects single (0) or dual (1) link mode
// - control bit 2 pages window 0x401-0x47E between link 0 and 1
// - enable bits: bit 0 link 0, bit 1 link 1; 00 none, 01 link 0
// - enable code 10 enables link 1 only, code 11 both links
module slrx_gen_ctrl (
    input  wire logic             i_clk_sys,
    input  wire logic             i_reset,
    input  wire slrx_pkg::slrx_req_t i_req,
    output logic       [7:0]      o_reg_rdata,
    output logic                  o_term_cal_group_b,
    output logic       [7:0]      o_term_setting_a,
    output logic       [7:0]      o_term_setting_b,
    output logic       [1:0]      o_link_en,
    output logic                  o_dual_link,
    output logic                  o_cksum_busy
);

    // ****************************************************************
    // address decode
    // ****************************************************************
    function automatic logic is_cfg(input logic [11:0] a);
        return (a >= slrx_pkg::ADDR_CFG_FIRST) &&
               (a <= slrx_pkg::ADDR_CFG_LAST);
    endfunction

    function automatic logic is_cksum(input logic [11:0] a);
        return (a >= slrx_pkg::ADDR_CKSUM_FIRST) &&
               (a <= slrx_pkg::ADDR_CKSUM_LAST) &&
               (a[2:0] == slrx_pkg::CKSUM_LANE_LSB);
    endfunction

    // sum of the link fields packed in one configuration byte
    function automatic logic [7:0] field_sum(input logic [3:0] idx,
                                             input logic [7:0] b);
        case (idx)
            4'h1:    return 8'(b[7:4]) + 8'(b[3:0]);
            4'h2:    return 8'(b[6]) + 8'(b[5]) + 8'(b[4:0]);
            4'h3:    return 8'(b[7]) + 8'(b[4:0]);
            4'h5:    return 8'(b[4:0]);
            4'h7:    return 8'(b[7:6]) + 8'(b[4:0]);
            4'h8:    return 8'(b[7:5]) + 8'(b[4:0]);
            4'h9:    return 8'(b[7:5]) + 8'(b[4:0]);
            4'ha:    return 8'(b[7]) + 8'(b[4:0]);
            default: return b;
        endcase
    endfunction

    slrx_pkg::slrx_ctrl_t ctrl_reg;
    logic                 cal_reg;
    logic [7:0]           set_a_reg;
    logic [7:0]           set_b_reg;
    logic                 cal_pulse_reg;
    logic [7:0]           cksum_reg [2];
    logic                 dirty_reg;
    slrx_pkg::slrx_seq_t  state_reg;
    logic                 link_reg;
    logic [3:0]           issue_reg;
    logic [3:0]           ret_idx_reg;
    logic                 rvalid_reg;
    logic [7:0]           acc_reg;
    logic [7:0]           mem_rdata;
    logic [4:0]           host_maddr;
    logic [4:0]           mem_raddr;
    logic                 host_busy;
    logic                 seq_issue;
    logic [7:0]           add_term;
    logic                 wr_ctrl;
    logic                 wr_cfg;

    assign wr_ctrl = i_req.wr && (i_req.addr == slrx_pkg::ADDR_RX_GEN_CTRL);
    assign wr_cfg  = i_req.wr && is_cfg(i_req.addr);

    // ****************************************************************
    // control registers
    // ****************************************************************
    // writable fields; reserved bits are dropped
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            ctrl_reg  <= '0;
            set_a_reg <= slrx_pkg::RST_TERM_SET_A;
            set_b_reg <= slrx_pkg::RST_TERM_SET_B;
            cal_reg   <= slrx_pkg::RST_TERM_CAL_B[0];
        end else if (i_req.wr) begin
            if (i_req.addr == slrx_pkg::ADDR_TERM_CAL_B) begin
                cal_reg <= i_req.wdata[slrx_pkg::BIT_TERM_CAL];
            end
            if (i_req.addr == slrx_pkg::ADDR_TERM_SET_A) begin
                set_a_reg <= i_req.wdata;
            end
            if (i_req.addr == slrx_pkg::ADDR_TERM_SET_B) begin
                set_b_reg <= i_req.wdata;
            end
            if (wr_ctrl) begin
                ctrl_reg.cksum_mode <= i_req.wdata[slrx_pkg::BIT_CKSUM_MODE];
                ctrl_reg.link_mode  <= i_req.wdata[slrx_pkg::BIT_LINK_MODE];
                ctrl_reg.link_page  <= i_req.wdata[slrx_pkg::BIT_LINK_PAGE];
                ctrl_reg.link_en    <= i_req.wdata[1:0];
            end
        end
    end

    // one-cycle calibration start on a 0 to 1 change of the bit
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            cal_pulse_reg <= 1'b0;
        end else begin
            cal_pulse_reg <= i_req.wr && !cal_reg &&
                             (i_req.addr == slrx_pkg::ADDR_TERM_CAL_B) &&
                             i_req.wdata[slrx_pkg::BIT_TERM_CAL];
        end
    end

    assign o_term_cal_group_b = cal_pulse_reg;
    assign o_term_setting_a   = set_a_reg;
    assign o_term_setting_b   = set_b_reg;
    assign o_link_en          = ctrl_reg.link_en;
    assign o_dual_link        = ctrl_reg.link_mode;
    assign o_cksum_busy       = (state_reg != slrx_pkg::SEQ_IDLE) || dirty_reg;

    // ****************************************************************
    // link configuration memory, paged
    // ****************************************************************
    // byte 0x400 is shared, the rest follow the link page
    assign host_maddr = {(i_req.addr != slrx_pkg::ADDR_CFG_FIRST) &&
                         ctrl_reg.link_page, i_req.addr[3:0]};
    assign host_busy  = i_req.rd && is_cfg(i_req.addr);
    assign seq_issue  = (state_reg == slrx_pkg::SEQ_RUN) && !host_busy &&
                        (issue_reg <= slrx_pkg::CFG_LAST_IDX);
    assign mem_raddr  = host_busy ? host_maddr :
                        {link_reg && (issue_reg != 4'h0), issue_reg};

    slrx_cfg_mem #(
        .DW (8),
        .AW (5)
    ) u_cfg_mem (
        .i_clk_sys (i_clk_sys),
        .i_reset   (i_reset),
        .i_we      (wr_cfg),
        .i_waddr   (host_maddr),
        .i_wdata   (i_req.wdata),
        .i_raddr   (mem_raddr),
        .o_rdata   (mem_rdata)
    );

    // ****************************************************************
    // checksum sequencer
    // ****************************************************************
    assign add_term = ctrl_reg.cksum_mode ? mem_rdata :
                      field_sum(ret_idx_reg, mem_rdata);

    // recompute request; a new write wins over the clear at start
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            dirty_reg <= 1'b0;
        end else if (wr_cfg || (wr_ctrl && (i_req.wdata[
                     slrx_pkg::BIT_CKSUM_MODE] != ctrl_reg.cksum_mode))) begin
            dirty_reg <= 1'b1;
        end else if (state_reg == slrx_pkg::SEQ_IDLE) begin
            dirty_reg <= 1'b0;
        end
    end

    // walk both links, bytes 0 to 10, accumulating modulo 256
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            state_reg   <= slrx_pkg::SEQ_IDLE;
            link_reg    <= 1'b0;
            issue_reg   <= 4'h0;
            ret_idx_reg <= 4'h0;
            rvalid_reg  <= 1'b0;
            acc_reg     <= 8'h00;
        end else begin
            rvalid_reg  <= seq_issue;
            ret_idx_reg <= issue_reg;
            unique case (state_reg)
                slrx_pkg::SEQ_IDLE: begin
                    if (dirty_reg) begin
                        state_reg <= slrx_pkg::SEQ_RUN;
                        link_reg  <= 1'b0;
                        issue_reg <= 4'h0;
                        acc_reg   <= 8'h00;
                    end
                end
                slrx_pkg::SEQ_RUN: begin
                    if (seq_issue) begin
                        issue_reg <= issue_reg + 4'h1;
                    end
                    if (rvalid_reg) begin
                        acc_reg <= acc_reg + add_term;
                        if (ret_idx_reg == slrx_pkg::CFG_LAST_IDX) begin
                            state_reg <= slrx_pkg::SEQ_DONE;
                        end
                    end
                end
                slrx_pkg::SEQ_DONE: begin
                    issue_reg <= 4'h0;
                    acc_reg   <= 8'h00;
                    link_reg  <= 1'b1;
                    state_reg <= link_reg ? slrx_pkg::SEQ_IDLE
                                          : slrx_pkg::SEQ_RUN;
                end
                default: begin
                    state_reg <= slrx_pkg::SEQ_IDLE;
                end
            endcase
        end
    end

    // store the finished sum for the link just walked
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            cksum_reg[0] <= slrx_pkg::RST_CKSUM;
            cksum_reg[1] <= slrx_pkg::RST_CKSUM;
        end else if (state_reg == slrx_pkg::SEQ_DONE) begin
            cksum_reg[link_reg] <= acc_reg;
        end
    end

    // ****************************************************************
    // read path, two cycles: select then output
    // ****************************************************************
    logic       rd_mem_reg;
    logic [7:0] rd_hold_reg;

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            rd_mem_reg  <= 1'b0;
            rd_hold_reg <= 8'h00;
        end else begin
            rd_mem_reg  <= host_busy;
            rd_hold_reg <= 8'h00;
            if (i_req.rd) begin
                if (i_req.addr == slrx_pkg::ADDR_TERM_CAL_B) begin
                    rd_hold_reg <= {7'h00, cal_reg};
                end else if (i_req.addr == slrx_pkg::ADDR_TERM_SET_A) begin
                    rd_hold_reg <= set_a_reg;
                end else if (i_req.addr == slrx_pkg::ADDR_TERM_SET_B) begin
                    rd_hold_reg <= set_b_reg;
                end else if (i_req.addr == slrx_pkg::ADDR_RX_GEN_CTRL) begin
                    rd_hold_reg <= {1'b0, ctrl_reg.cksum_mode, 2'b00,
                                    ctrl_reg.link_mode, ctrl_reg.link_page,
                                    ctrl_reg.link_en};
                end else if (is_cksum(i_req.addr)) begin
                    rd_hold_reg <= cksum_reg[ctrl_reg.link_page];
                end
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_reg_rdata <= 8'h00;
        end else begin
            o_reg_rdata <= rd_mem_reg ? mem_rdata : rd_hold_reg;
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    AST_CAL_PULSE: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        $rose(cal_reg) |-> o_term_cal_group_b ##1 !o_term_cal_group_b)
        else $error("calibration pulse missing on bit rise");

    AST_CK_FIELDS: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (state_reg == slrx_pkg::SEQ_RUN && rvalid_reg && !ctrl_reg.cksum_mode
         && ret_idx_reg == 4'h1) |=>
        acc_reg == $past(acc_reg) + 8'($past(mem_rdata[7:4]))
                   + 8'($past(mem_rdata[3:0])))
        else $error("field checksum term wrong");

    AST_CK_BYTES: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (state_reg == slrx_pkg::SEQ_RUN && rvalid_reg && ctrl_reg.cksum_mode)
        |=> acc_reg == $past(acc_reg) + $past(mem_rdata))
        else $error("byte checksum term wrong");

    AST_CK_STORE: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (state_reg == slrx_pkg::SEQ_DONE) |=>
        cksum_reg[$past(link_reg)] == $past(acc_reg))
        else $error("lane checksum not stored");

    AST_LINK_MODE: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        wr_ctrl |=> o_dual_link == $past(i_req.wdata[3]))
        else $error("link mode not taken from bit 3");

    AST_PAGE_READ: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (i_req.rd && is_cksum(i_req.addr)) |-> ##2
        o_reg_rdata == $past(ctrl_reg.link_page ? cksum_reg[1]
                                                : cksum_reg[0], 2))
        else $error("paged checksum read wrong");

    AST_EN_NONE: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (wr_ctrl && i_req.wdata[1:0] == 2'b00) |=> o_link_en == 2'b00)
        else $error("links not disabled by code 00");

    AST_EN_LINK0: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (wr_ctrl && i_req.wdata[1:0] == 2'b01) |=> o_link_en == 2'b01)
        else $error("code 01 must enable link 0 only");

    AST_EN_LINK1: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (wr_ctrl && i_req.wdata[1]) |=>
        o_link_en[1] && o_link_en[0] == $past(i_req.wdata[0]))
        else $error("codes 10 and 11 decode wrong");

endmodule

/* File: test/slrx_host.sv */
`timescale 1ns/1ps
// host model: issues byte requests on the register port
module slrx_host (
    input  wire logic                 i_clk_sys,
    input  wire logic [7:0]           i_rdata,
    output slrx_pkg::slrx_req_t       o_req
);
    logic cfg_ready;   // link setup, pll lock, phy power and calibration done

    // ****************************************************************
    // idle state at time zero
    // ****************************************************************
    initial begin
        o_req = '0;
        cfg_ready = 1'b0;
    end

    // ****************************************************************
    // access tasks
    // ****************************************************************
    // one write; address and data scrambled once released
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(negedge i_clk_sys);
        o_req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
        @(negedge i_clk_sys);
        o_req = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
    endtask

    // one read; data sampled one and a half cycles after the taking edge
    task automatic rd(input logic [11:0] a, output logic [7:0] d);
        @(negedge i_clk_sys);
        o_req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h5a};
        @(negedge i_clk_sys);
        o_req = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: 8'ha5};
        @(negedge i_clk_sys);
        d = i_rdata;
    endtask

    // ****************************************************************
    // bring-up duties of the host
    // ****************************************************************
    // termination settings the receiver needs
    task automatic term_setup();
        wr(slrx_pkg::ADDR_TERM_SET_A, 8'hb7);
        wr(slrx_pkg::ADDR_TERM_SET_B, 8'h87);
    endtask

    // all preconditions met, enables may now be set
    task automatic mark_ready();
        cfg_ready = 1'b1;
    endtask

    // control write that may carry link enables
    task automatic enable(input logic [7:0] d);
        if (cfg_ready) begin
            wr(slrx_pkg::ADDR_RX_GEN_CTRL, d);
        end
    endtask
endmodule

/* File: test/tb.sv */
`timescale 1ns/1ps
// register bank testbench
module tb;
    logic                i_clk_sys;
    logic                i_reset;
    slrx_pkg::slrx_req_t req;
    logic [7:0]          rdata;
    logic                cal_pulse;
    logic [7:0]          set_a;
    logic [7:0]          set_b;
    logic [1:0]          link_en;
    logic                dual_link;
    logic                busy;
    int                  fails;
    int                  comparisons;
    logic [7:0]          cfg [2][11];
    logic [7:0]          v;

    // ****************************************************************
    // clock, host and design
    // ****************************************************************
    // 100 mhz system clock
    initial begin
        i_clk_sys = 1'b0;
        forever #5 i_clk_sys = ~i_clk_sys;
    end

    slrx_host i_host (
        .i_clk_sys (i_clk_sys),
        .i_rdata   (rdata),
        .o_req     (req)
    );

    slrx_gen_ctrl i_dut (
        .i_clk_sys          (i_clk_sys),
        .i_reset            (i_reset),
        .i_req              (req),
        .o_reg_rdata        (rdata),
        .o_term_cal_group_b (cal_pulse),
        .o_term_setting_a   (set_a),
        .o_term_setting_b   (set_b),
        .o_link_en          (link_en),
        .o_dual_link        (dual_link),
        .o_cksum_busy       (busy)
    );

    // ****************************************************************
    // helpers
    // ****************************************************************
    // compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    // read one register and compare
    task automatic rchk(input logic [11:0] a, input logic [7:0] exp);
        i_host.rd(a, v);
        check(v, exp);
    endtask

    // verdict and end of run
    task automatic finish_test();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // bounded wait for the checksum sequencer to go idle
    task automatic wait_idle();
        int n;
        n = 0;
        @(negedge i_clk_sys);
        while (busy !== 1'b0 && n < 200) begin
            @(negedge i_clk_sys);
            n++;
        end
        if (n >= 200) begin
            fails++;
            finish_test();
        end
    endtask

    // expected checksum of one link in either mode
    function automatic logic [7:0] cs(input int l, input logic m);
        logic [7:0] s;
        s = 8'h00;
        if (m) begin
            for (int i = 0; i < 11; i++) s = s + cfg[l][i];
        end else begin
            s = cfg[l][0] + cfg[l][4] + cfg[l][6];
            s = s + cfg[l][1][7:4] + cfg[l][1][3:0];
            s = s + cfg[l][2][6] + cfg[l][2][5] + cfg[l][2][4:0];
            s = s + cfg[l][3][7] + cfg[l][3][4:0] + cfg[l][5][4:0];
            s = s + cfg[l][7][7:6] + cfg[l][7][4:0];
            s = s + cfg[l][8][7:5] + cfg[l][8][4:0];
            s = s + cfg[l][9][7:5] + cfg[l][9][4:0];
            s = s + cfg[l][10][7] + cfg[l][10][4:0];
        end
        return s;
    endfunction

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        fails = 0;
        comparisons = 0;
        i_reset = 1'b1;
        repeat (2) @(negedge i_clk_sys);
        i_reset = 1'b0;
        // reset values and an unmapped address
        check(set_a, 8'hc3);
        check(set_b, 8'h93);
        check({6'h0, link_en}, 8'h00);
        check({7'h0, dual_link}, 8'h00);
        check({7'h0, busy}, 8'h00);
        check({7'h0, cal_pulse}, 8'h00);
        rchk(12'h2ae, 8'h00);
        rchk(12'h2b1, 8'hc3);
        rchk(12'h2b2, 8'h93);
        rchk(12'h300, 8'h00);
        rchk(12'h40e, 8'h00);
        rchk(12'h123, 8'h00);
        // termination settings written by the host
        i_host.term_setup();
        check(set_a, 8'hb7);
        check(set_b, 8'h87);
        rchk(12'h2b1, 8'hb7);
        rchk(12'h2b2, 8'h87);
        // calibration only on a rising edge of the bit
        i_host.wr(12'h2ae, 8'h01);
        check({7'h0, cal_pulse}, 8'h01);
        @(negedge i_clk_sys);
        check({7'h0, cal_pulse}, 8'h00);
        i_host.wr(12'h2ae, 8'hff);
        check({7'h0, cal_pulse}, 8'h00);
        rchk(12'h2ae, 8'h01);
        i_host.wr(12'h2ae, 8'hfe);
        rchk(12'h2ae, 8'h00);
        i_host.wr(12'h2ae, 8'h01);
        check({7'h0, cal_pulse}, 8'h01);
        // link parameters of both pages, 0x400 shared
        for (int l = 0; l < 2; l++) begin
            i_host.wr(12'h300, {5'h0, l[0], 2'h0});
            for (int i = 0; i < 11; i++) begin
                cfg[l][i] = 8'(i * 37 + l * 91 + 5);
                if (l == 1 && i == 0) cfg[l][i] = cfg[0][0];
                if (l == 0 || i > 0) i_host.wr(12'h400 + 12'(i), cfg[l][i]);
            end
        end
        // checksums in both modes, on every lane and page
        for (int m = 0; m < 2; m++) begin
            i_host.wr(12'h300, {1'b0, m[0], 6'h0});
            if (m == 1) check({7'h0, busy}, 8'h01);
            wait_idle();
            i_host.wr(12'h40e, 8'h5a);
            for (int p = 0; p < 2; p++) begin
                i_host.wr(12'h300, {1'b0, m[0], 3'h0, p[0], 2'h0});
                rchk(12'h405, cfg[p][5]);
                rchk(12'h400, cfg[0][0]);
                for (int k = 0; k < 8; k++) begin
                    rchk(12'h40e + 12'(8 * k), cs(p, m[0]));
                end
            end
        end
        // every enable code, link mode dual for codes 00 and 10, single for 01 and 11
        i_host.mark_ready();
        for (int c = 0; c < 4; c++) begin
            i_host.enable({1'b1, 1'b1, 2'h3, ~c[0], 1'b0, c[1:0]});
            check({6'h0, link_en}, 8'(c));
            check({7'h0, dual_link}, {7'h0, ~c[0]});
            rchk(12'h300, {4'h4, ~c[0], 1'b0, c[1:0]});
        end
        finish_test();
    end
endmodule
